/* rtl/bcca_map.vh */
/*
 * Constants for the BCD calendar clock with alarm: counter limits,
 * reset values, alarm enable bit positions and tick generator figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef BCCA_MAP_VH
`define BCCA_MAP_VH

// ***********************************************************
// Tick generator
// ***********************************************************
`define BCCA_POST_BASE_W   8          // Post-scaler step is 2^8 = 256
`define BCCA_TENTHS_LAST   4'h9       // Tenth ticks per second minus one

// ***********************************************************
// BCD counter limits
// ***********************************************************
`define BCCA_SEC_LAST      7'h59
`define BCCA_MIN_LAST      7'h59
`define BCCA_HOUR24_LAST   6'h23
`define BCCA_HOUR12_TOP    6'h12
`define BCCA_HOUR12_PRE    6'h11
`define BCCA_DOW_LAST      3'h7
`define BCCA_MONTH_LAST    5'h12
`define BCCA_MONTH_FEB     5'h02
`define BCCA_YEAR_LAST     16'h9999

// ***********************************************************
// Reset values
// ***********************************************************
`define BCCA_TENTH_RST     4'h0
`define BCCA_SEC_RST       7'h00
`define BCCA_MIN_RST       7'h00
`define BCCA_HOUR_RST      6'h00
`define BCCA_DOW_RST       3'h1
`define BCCA_DOM_RST       6'h01
`define BCCA_MONTH_RST     5'h01
`define BCCA_YEAR_RST      16'h2000

// ***********************************************************
// Alarm field enable bit positions
// ***********************************************************
`define BCCA_AEN_TENTH     0
`define BCCA_AEN_SEC       1
`define BCCA_AEN_MIN       2
`define BCCA_AEN_HOUR      3
`define BCCA_AEN_DOW       4
`define BCCA_AEN_DOM       5
`define BCCA_AEN_MONTH     6
`define BCCA_AEN_YEAR      7

`endif

/* rtl/bcca_tick.v */
/*
 * Tick generator: fractional divider, optional smoother, post-scaler
 * of 256 times a multiple, and an optional divide by ten for seconds.
 * Assumes all configuration inputs are static or on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bcca_map.vh"

module bcca_tick
(
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // Configuration
    input  wire [15:0] int_div,
    input  wire [7:0]  frac,
    input  wire        smooth_en,
    input  wire [7:0]  post_mult,
    input  wire        sec_sel,
    // Tick out
    output reg         tick
);

    reg  [15:0] div_cnt;
    reg  [7:0]  sd_acc;
    reg  [15:0] post_cnt;
    reg  [3:0]  dec_cnt;

    // ***********************************************************
    // Fractional divider
    // ***********************************************************
    // Smoothed: sigma-delta spreads the extra cycles evenly.
    // Raw: the extra cycles bunch at the start of each 256 block;
    // both give the same average since one block spans 256 periods.
    wire [8:0]  sd_sum     = {1'b0, sd_acc} + {1'b0, frac};
    wire        extra      = smooth_en ? sd_sum[8] : (post_cnt[7:0] < frac);
    wire [15:0] div_base   = (int_div == 16'h0000) ? 16'h0001 : int_div;
    wire [15:0] div_load   = div_base - 16'h0001 + {15'h0000, extra};
    wire        div_pulse  = (div_cnt == 16'h0000);

    // ***********************************************************
    // Post-scaler
    // ***********************************************************
    wire [7:0]  blocks     = (post_mult == 8'h00) ? 8'h01 : post_mult;
    wire        post_end   = div_pulse && (post_cnt == {blocks - 8'h01, 8'hff});
    wire        dec_end    = (dec_cnt == `BCCA_TENTHS_LAST);

    // Divider, accumulator and scaler state
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt  <= 16'h0000;
            sd_acc   <= 8'h00;
            post_cnt <= 16'h0000;
            dec_cnt  <= 4'h0;
            tick     <= 1'b0;
        end
        else
        begin
            if (div_pulse)
            begin
                div_cnt  <= div_load;
                sd_acc   <= sd_sum[7:0];
                post_cnt <= post_end ? 16'h0000 : post_cnt + 16'h0001;
            end
            else
                div_cnt  <= div_cnt - 16'h0001;
            if (post_end)
                dec_cnt  <= dec_end ? 4'h0 : dec_cnt + 4'h1;
            tick <= sec_sel ? (post_end && dec_end) : post_end;
        end
    end

endmodule // bcca_tick
`default_nettype wire

/* rtl/bcca_match.v */
/*
 * Alarm comparator: each field is compared under its own enable; a
 * disabled field counts as a match. Purely combinational.
 * Assumes current and alarm values share one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bcca_map.vh"

module bcca_match
(
    // Current time and date
    input  wire [3:0]  cur_tenth,
    input  wire [6:0]  cur_sec,
    input  wire [6:0]  cur_min,
    input  wire [6:0]  cur_hour,
    input  wire [2:0]  cur_dow,
    input  wire [5:0]  cur_dom,
    input  wire [4:0]  cur_month,
    input  wire [15:0] cur_year,
    // Alarm time and date
    input  wire [3:0]  alm_tenth,
    input  wire [6:0]  alm_sec,
    input  wire [6:0]  alm_min,
    input  wire [6:0]  alm_hour,
    input  wire [2:0]  alm_dow,
    input  wire [5:0]  alm_dom,
    input  wire [4:0]  alm_month,
    input  wire [15:0] alm_year,
    input  wire [7:0]  alm_en,
    // Result
    output wire        match
);

    // Per-field hit: equal, or the field is left out
    wire [7:0] hit;
    assign hit[`BCCA_AEN_TENTH] = !alm_en[`BCCA_AEN_TENTH] || (cur_tenth == alm_tenth);
    assign hit[`BCCA_AEN_SEC]   = !alm_en[`BCCA_AEN_SEC]   || (cur_sec   == alm_sec);
    assign hit[`BCCA_AEN_MIN]   = !alm_en[`BCCA_AEN_MIN]   || (cur_min   == alm_min);
    assign hit[`BCCA_AEN_HOUR]  = !alm_en[`BCCA_AEN_HOUR]  || (cur_hour  == alm_hour);
    assign hit[`BCCA_AEN_DOW]   = !alm_en[`BCCA_AEN_DOW]   || (cur_dow   == alm_dow);
    assign hit[`BCCA_AEN_DOM]   = !alm_en[`BCCA_AEN_DOM]   || (cur_dom   == alm_dom);
    assign hit[`BCCA_AEN_MONTH] = !alm_en[`BCCA_AEN_MONTH] || (cur_month == alm_month);
    assign hit[`BCCA_AEN_YEAR]  = !alm_en[`BCCA_AEN_YEAR]  || (cur_year  == alm_year);
    assign match = &hit;

endmodule // bcca_match
`default_nettype wire

/* rtl/bcca_top.v */
/*
 * BCD calendar clock with alarm: tick generator, cascaded BCD time and
 * date counters, alarm comparison and two alarm interrupt outputs.
 * Assumes one clock; control bits are plain ports driven on this clock,
 * except bus_clk_on which comes from elsewhere and is synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bcca_map.vh"

// Behaviour
// - Keep time and date in cascaded BCD counters, resolved to tenths.
// - Bypass of tenths makes seconds advance directly on each tick.
// - Alarm is compared against the counters on every update.
// - Each alarm field has its own enable; disabled fields always match.
// - Alarm raises a bus-side interrupt only while the bus clock runs.
// - Alarm raises a wake interrupt, issued even with bus clock gated.
// - Ticks are one second or one tenth, chosen by configuration.
// - Fractional divider feeds post-scaler dividing by multiples of 256.
// - Optional smoother evens divider pulse spacing; tick spacing is the same with it on or off.
// - Day-of-month rollover honours leap years for February.
// - Hours count in 12-hour with AM/PM or 24-hour mode.
module bcca_top
(
    // Clock and reset
    input  wire        clock,
    input  wire        arst_n,
    // Tick generator configuration
    input  wire [15:0] int_div,
    input  wire [7:0]  frac,
    input  wire        smooth_en,
    input  wire [7:0]  post_mult,
    input  wire        sec_sel,
    // Calendar configuration
    input  wire        tenth_bypass,
    input  wire        mode_12h,
    // Time and date load
    input  wire        set_stb,
    input  wire [3:0]  set_tenth,
    input  wire [6:0]  set_sec,
    input  wire [6:0]  set_min,
    input  wire [5:0]  set_hour,
    input  wire        set_pm,
    input  wire [2:0]  set_dow,
    input  wire [5:0]  set_dom,
    input  wire [4:0]  set_month,
    input  wire [15:0] set_year,
    // Alarm settings
    input  wire [3:0]  alm_tenth,
    input  wire [6:0]  alm_sec,
    input  wire [6:0]  alm_min,
    input  wire [5:0]  alm_hour,
    input  wire        alm_pm,
    input  wire [2:0]  alm_dow,
    input  wire [5:0]  alm_dom,
    input  wire [4:0]  alm_month,
    input  wire [15:0] alm_year,
    input  wire [7:0]  alm_en,
    // Interrupt control
    input  wire        bus_clk_on,
    input  wire        irq_bus_en,
    input  wire        irq_bus_clr,
    input  wire        irq_wake_en,
    input  wire        irq_wake_clr,
    output wire        irq_bus,
    output wire        irq_wake,
    output reg         irq_bus_pend,
    output reg         irq_wake_pend,
    // Snapshot read
    input  wire        snap_req,
    output reg         snap_valid,
    output reg  [3:0]  snap_tenth,
    output reg  [6:0]  snap_sec,
    output reg  [6:0]  snap_min,
    output reg  [5:0]  snap_hour,
    output reg         snap_pm,
    output reg  [2:0]  snap_dow,
    output reg  [5:0]  snap_dom,
    output reg  [4:0]  snap_month,
    output reg  [15:0] snap_year
);

    // ***********************************************************
    // BCD helper functions
    // ***********************************************************
    // Increment a two-digit BCD value
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9)
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            else
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // Two BCD digits divisible by four
    function div4;
        input [7:0] v;
        begin
            if (v[4])
                div4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
            else
                div4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
        end
    endfunction

    // Last day of a month in BCD
    function [5:0] month_len;
        input [4:0] m;
        input       leap;
        begin
            case (m)
                5'h02:   month_len = leap ? 6'h29 : 6'h28;
                5'h04, 5'h06, 5'h09, 5'h11: month_len = 6'h30;
                default: month_len = 6'h31;
            endcase
        end
    endfunction

    // ***********************************************************
    // Registers and next values
    // ***********************************************************
    reg  [3:0]  tenth, next_tenth;
    reg  [6:0]  sec, next_sec;
    reg  [6:0]  minute, next_minute;
    reg  [5:0]  hour, next_hour;
    reg         pm, next_pm;
    reg  [2:0]  dow, next_dow;
    reg  [5:0]  dom, next_dom;
    reg  [4:0]  month, next_month;
    reg  [15:0] year, next_year;
    reg         c_sec, c_min, c_hour, c_day, c_month, c_year;
    reg         upd;
    reg         bus_on_m, bus_on;
    wire        tick;
    wire        match;
    wire [7:0]  sum_sec, sum_min, sum_hour, sum_dom, sum_mon, sum_ylo, sum_yhi;

    // Reset image of the counters, also the snapshot until the first read
    localparam [54:0] rst_all = {`BCCA_TENTH_RST, `BCCA_SEC_RST, `BCCA_MIN_RST, `BCCA_HOUR_RST, 1'b0,
        `BCCA_DOW_RST, `BCCA_DOM_RST, `BCCA_MONTH_RST, `BCCA_YEAR_RST};

    // ***********************************************************
    // Tick generator and alarm comparator
    // ***********************************************************
    bcca_tick u_tick
    (
        .clock     (clock),
        .arst_n    (arst_n),
        .int_div   (int_div),
        .frac      (frac),
        .smooth_en (smooth_en),
        .post_mult (post_mult),
        .sec_sel   (sec_sel),
        .tick      (tick)
    );

    // The hour compare includes the AM/PM bit so 12-hour alarms are exact
    bcca_match u_match
    (
        .cur_tenth (tenth),
        .cur_sec   (sec),
        .cur_min   (minute),
        .cur_hour  ({pm, hour}),
        .cur_dow   (dow),
        .cur_dom   (dom),
        .cur_month (month),
        .cur_year  (year),
        .alm_tenth (alm_tenth),
        .alm_sec   (alm_sec),
        .alm_min   (alm_min),
        .alm_hour  ({alm_pm, alm_hour}),
        .alm_dow   (alm_dow),
        .alm_dom   (alm_dom),
        .alm_month (alm_month),
        .alm_year  (alm_year),
        .alm_en    (alm_en),
        .match     (match)
    );

    // ***********************************************************
    // Calendar cascade
    // ***********************************************************
    assign sum_sec  = bcd_inc({1'b0, sec});
    assign sum_min  = bcd_inc({1'b0, minute});
    assign sum_hour = bcd_inc({2'b00, hour});
    assign sum_dom  = bcd_inc({2'b00, dom});
    assign sum_mon  = bcd_inc({3'b000, month});
    assign sum_ylo  = bcd_inc(year[7:0]);
    assign sum_yhi  = bcd_inc(year[15:8]);
    // Century years are leap only when the century is divisible by four
    wire leap = (year[7:0] == 8'h00) ? div4(year[15:8]) : div4(year[7:0]);

    // Each stage moves only on the carry of the stage below
    always @*
    begin
        next_tenth  = tenth;
        next_sec    = sec;
        next_minute = minute;
        next_hour   = hour;
        next_pm     = pm;
        next_dow    = dow;
        next_dom    = dom;
        next_month  = month;
        next_year   = year;
        c_sec       = tick && (tenth_bypass || tenth == `BCCA_TENTHS_LAST);
        c_min       = 1'b0;
        c_hour      = 1'b0;
        c_day       = 1'b0;
        c_month     = 1'b0;
        c_year      = 1'b0;
        if (tenth_bypass)
            next_tenth = `BCCA_TENTH_RST;
        else if (tick)
            next_tenth = (tenth == `BCCA_TENTHS_LAST) ? 4'h0 : tenth + 4'h1;
        if (c_sec)
        begin
            c_min    = (sec == `BCCA_SEC_LAST);
            next_sec = c_min ? 7'h00 : sum_sec[6:0];
        end
        if (c_min)
        begin
            c_hour      = (minute == `BCCA_MIN_LAST);
            next_minute = c_hour ? 7'h00 : sum_min[6:0];
        end
        if (c_hour)
        begin
            if (mode_12h)
            begin
                // 11 -> 12 flips AM/PM; day ends at 11 PM -> 12 AM
                if (hour == `BCCA_HOUR12_PRE)
                begin
                    next_hour = `BCCA_HOUR12_TOP;
                    next_pm   = !pm;
                    c_day     = pm;
                end
                else if (hour == `BCCA_HOUR12_TOP)
                    next_hour = 6'h01;
                else
                    next_hour = sum_hour[5:0];
            end
            else
            begin
                c_day     = (hour == `BCCA_HOUR24_LAST);
                next_hour = c_day ? 6'h00 : sum_hour[5:0];
                next_pm   = 1'b0;
            end
        end
        if (c_day)
        begin
            next_dow = (dow == `BCCA_DOW_LAST) ? 3'h1 : dow + 3'h1;
            c_month  = (dom == month_len(month, leap));
            next_dom = c_month ? 6'h01 : sum_dom[5:0];
        end
        if (c_month)
        begin
            c_year     = (month == `BCCA_MONTH_LAST);
            next_month = c_year ? 5'h01 : sum_mon[4:0];
        end
        if (c_year)
            next_year = (year == `BCCA_YEAR_LAST) ? 16'h0000 :
                        (year[7:0] == 8'h99) ? {sum_yhi, 8'h00} : {year[15:8], sum_ylo};
    end

    // Counter state; a load from software overrides the tick
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {tenth, sec, minute, hour, pm, dow, dom, month, year} <= rst_all;
            upd <= 1'b0;
        end
        else
        begin
            upd <= tick || set_stb;
            if (set_stb)
                {tenth, sec, minute, hour, pm, dow, dom, month, year} <= {set_tenth, set_sec, set_min, set_hour,
                    set_pm, set_dow, set_dom, set_month, set_year};
            else
                {tenth, sec, minute, hour, pm, dow, dom, month, year} <= {next_tenth, next_sec, next_minute,
                    next_hour, next_pm, next_dow, next_dom, next_month, next_year};
        end
    end

    // ***********************************************************
    // Alarm interrupts
    // ***********************************************************
    // Compare after every counter update, one cycle behind the change
    wire alarm_hit = upd && match;

    // Presence sync and pending flags: a new alarm wins over a clear in the same cycle
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_on_m      <= 1'b0;
            bus_on        <= 1'b0;
            irq_bus_pend  <= 1'b0;
            irq_wake_pend <= 1'b0;
        end
        else
        begin
            bus_on_m      <= bus_clk_on;                                // Other domain: two flops first
            bus_on        <= bus_on_m;
            irq_bus_pend  <= (alarm_hit && bus_on) || (irq_bus_pend && !irq_bus_clr);
            irq_wake_pend <= alarm_hit || (irq_wake_pend && !irq_wake_clr);
        end
    end

    // The wake line ignores bus clock state so it can end power-down
    assign irq_bus  = irq_bus_pend && irq_bus_en && bus_on;
    assign irq_wake = irq_wake_pend && irq_wake_en;

    // ***********************************************************
    // Snapshot
    // ***********************************************************
    // All fields captured on one edge, so a carry never tears the read
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            snap_valid <= 1'b0;
            {snap_tenth, snap_sec, snap_min, snap_hour, snap_pm, snap_dow, snap_dom, snap_month,
                snap_year} <= rst_all;
        end
        else
        begin
            snap_valid <= snap_req;
            if (snap_req)
                {snap_tenth, snap_sec, snap_min, snap_hour, snap_pm, snap_dow, snap_dom, snap_month,
                    snap_year} <= {tenth, sec, minute, hour, pm, dow, dom, month, year};
        end
    end

endmodule // bcca_top
`default_nettype wire

/* verif/bcca_bus_side.sv */
/* Far side model: bus clock presence as the device sees it.
   Assumes the bench drives gate_off to stop or restart the bus clock. */
`timescale 1ns/1ns
`default_nettype none
module bcca_bus_side
(
    // Gate request
    input  wire logic gate_off,
    // Presence level, asynchronous to the counter clock
    output wire logic bus_clk_on
);
    // Lags the gate so the device must synchronise it
    assign #3 bus_clk_on = !gate_off;
endmodule // bcca_bus_side
`default_nettype wire

/* verif/bcca_assertions.sv */
/* Checker for alarm, interrupt and snapshot behaviour.
   Assumes it is bound to bcca_top with implicit named ports. */
`timescale 1ns/1ns
`default_nettype none
module bcca_assertions
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // Observed ports
    input wire logic        set_stb,
    input wire logic [4:0]  set_month,
    input wire logic [15:0] set_year,
    input wire logic [7:0]  alm_en,
    input wire logic        bus_clk_on,
    input wire logic        irq_bus_clr,
    input wire logic        irq_wake_en,
    input wire logic        irq_wake_clr,
    input wire logic        irq_bus,
    input wire logic        irq_wake,
    input wire logic        irq_bus_pend,
    input wire logic        irq_wake_pend,
    input wire logic        snap_req,
    input wire logic        snap_valid,
    input wire logic [4:0]  snap_month,
    input wire logic [15:0] snap_year
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_snap_answer; snap_req |=> snap_valid; endproperty
    a_snap_answer: assert property (p_snap_answer) else $error("snapshot not answered");
    property p_snap_single; !snap_req |=> !snap_valid; endproperty
    a_snap_single: assert property (p_snap_single) else $error("stray snapshot valid");
    property p_snap_hold; !snap_req |=> $stable(snap_year) && $stable(snap_month); endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");
    property p_load_seen;
        set_stb ##1 snap_req |=> snap_year == $past(set_year, 2) && snap_month == $past(set_month, 2);
    endproperty
    a_load_seen: assert property (p_load_seen) else $error("load not in snapshot");
    property p_open_alarm; set_stb && alm_en == 8'h00 |-> ##[1:2] irq_wake_pend; endproperty
    a_open_alarm: assert property (p_open_alarm) else $error("open alarm missed");
    property p_wake_gate; irq_wake |-> irq_wake_en && irq_wake_pend; endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake irq ungated");
    property p_bus_gate; !bus_clk_on [*3] |-> !irq_bus; endproperty
    a_bus_gate: assert property (p_bus_gate) else $error("bus irq while gated");
    property p_wake_hold; irq_wake_pend && !irq_wake_clr |=> irq_wake_pend; endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake pend lost");
    property p_bus_hold; irq_bus_pend && !irq_bus_clr |=> irq_bus_pend; endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus pend lost");
    property p_wake_clear; $fell(irq_wake_pend) |-> $past(irq_wake_clr); endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake pend dropped");
    c_snap: cover property (snap_valid);
    c_wake: cover property ($rose(irq_wake));
    c_bus: cover property ($rose(irq_bus));
endmodule // bcca_assertions
`default_nettype wire

/* verif/testbench.sv */
/* Testbench: calendar rollovers, tick spacing and alarm interrupts.
   Assumes the design, bus side model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] int_div = 16'h0001;
    logic [7:0]  frac = 8'h00;
    logic        smooth_en = 1'b0;
    logic [7:0]  post_mult = 8'h01;
    logic        sec_sel = 1'b0;
    logic        tenth_bypass = 1'b0;
    logic        mode_12h = 1'b0;
    logic        set_stb = 1'b0;
    logic        snap_req = 1'b0;
    logic        gate_off = 1'b1;
    logic [1:0]  irq_clr = 2'h0;
    logic [1:0]  irq_en = 2'h3;
    logic [7:0]  alm_en = 8'hff;
    logic [54:0] set_all = 55'h0;
    logic [54:0] alm_all = 55'h1; // Year 0001, never reached
    wire  [54:0] snap_all;
    wire         bus_clk_on, irq_bus, irq_wake, irq_bus_pend, irq_wake_pend, snap_valid;
    int          n_errors = 0;
    int          checked = 0;
    bcca_top bcca_top_inst
    (
        .clock(clock), .arst_n(arst_n), .int_div(int_div), .frac(frac), .smooth_en(smooth_en),
        .post_mult(post_mult), .sec_sel(sec_sel), .tenth_bypass(tenth_bypass), .mode_12h(mode_12h),
        .set_stb(set_stb), .set_tenth(set_all[54:51]), .set_sec(set_all[50:44]), .set_min(set_all[43:37]),
        .set_hour(set_all[36:31]), .set_pm(set_all[30]), .set_dow(set_all[29:27]), .set_dom(set_all[26:21]),
        .set_month(set_all[20:16]), .set_year(set_all[15:0]), .alm_tenth(alm_all[54:51]),
        .alm_sec(alm_all[50:44]), .alm_min(alm_all[43:37]), .alm_hour(alm_all[36:31]), .alm_pm(alm_all[30]),
        .alm_dow(alm_all[29:27]), .alm_dom(alm_all[26:21]), .alm_month(alm_all[20:16]),
        .alm_year(alm_all[15:0]), .alm_en(alm_en), .bus_clk_on(bus_clk_on), .irq_bus_en(irq_en[1]),
        .irq_bus_clr(irq_clr[1]), .irq_wake_en(irq_en[0]), .irq_wake_clr(irq_clr[0]), .irq_bus(irq_bus),
        .irq_wake(irq_wake), .irq_bus_pend(irq_bus_pend), .irq_wake_pend(irq_wake_pend),
        .snap_req(snap_req), .snap_valid(snap_valid), .snap_tenth(snap_all[54:51]),
        .snap_sec(snap_all[50:44]), .snap_min(snap_all[43:37]), .snap_hour(snap_all[36:31]),
        .snap_pm(snap_all[30]), .snap_dow(snap_all[29:27]), .snap_dom(snap_all[26:21]),
        .snap_month(snap_all[20:16]), .snap_year(snap_all[15:0])
    );
    bcca_bus_side bcca_bus_side_inst (.gate_off(gate_off), .bus_clk_on(bus_clk_on));
    // Free-running 100 MHz clock
    initial forever #5 clock = ~clock;
    // Packs BCD fields in snapshot order
    function automatic logic [54:0] t(input logic [3:0] a, input logic [6:0] s, input logic [6:0] m,
        input logic [5:0] h, input logic p, input logic [2:0] w, input logic [5:0] d, input logic [4:0] o,
        input logic [15:0] y);
        return {a, s, m, h, p, w, d, o, y};
    endfunction
    task chk(input logic [54:0] got, input logic [54:0] exp);
    begin
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // Entered just after a rising edge
    task snap;
    begin
        snap_req <= 1'b1;
        @(posedge clock) snap_req <= 1'b0;
        @(negedge clock) chk(55'(snap_valid), 55'h1);
    end
    endtask
    // Snapshots until the time moves; bounded so a dead tick cannot hang
    task poll(output int i);
        logic [54:0] prev;
    begin
        prev = snap_all;
        i = 0;
        do
        begin
            @(posedge clock) snap;
            i++;
        end
        while (snap_all === prev && i < 3000);
    end
    endtask
    // Snapshot taken on the edge after the load so no tick can slip in between
    task step(input logic [54:0] from, input logic [54:0] exp);
        int n;
    begin
        @(posedge clock) set_all <= from;
        set_stb <= 1'b1;
        @(posedge clock) set_stb <= 1'b0;
        snap;
        chk(snap_all, from);
        poll(n);
        chk(snap_all, exp);
    end
    endtask
    // First gap after a change of setup is discarded
    task gap(input int k);
        int n;
    begin
        poll(n);
        poll(n);
        chk(55'(n), 55'(k));
    end
    endtask
    task flags(input logic [3:0] e);
    begin
        repeat (3) @(posedge clock);
        @(negedge clock) chk(55'({irq_wake_pend, irq_wake, irq_bus_pend, irq_bus}), 55'(e));
    end
    endtask
    task clr;
    begin
        @(posedge clock) irq_clr <= 2'h3;
        @(posedge clock) irq_clr <= 2'h0;
    end
    endtask
    task stop_test;
    begin
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock) chk(snap_all, t(4'h0,7'h00,7'h00,6'h00,1'b0,3'h1,6'h01,5'h01,16'h2000));
        @(posedge clock) alm_all <= t(4'h0,7'h00,7'h00,6'h00,1'b0,3'h1,6'h29,5'h02,16'h2024);
        clr;
        step(t(4'h9,7'h59,7'h59,6'h23,1'b0,3'h7,6'h28,5'h02,16'h2024), alm_all);
        flags(4'hc);
        clr;
        flags(4'h0);
        @(posedge clock) gate_off <= 1'b0;
        step(t(4'h9,7'h59,7'h59,6'h23,1'b0,3'h7,6'h28,5'h02,16'h2024), alm_all);
        flags(4'hf);
        @(posedge clock) irq_en <= 2'h0;
        flags(4'ha);
        clr;
        @(posedge clock) irq_en <= 2'h3;
        mode_12h <= 1'b1;
        step(t(4'h9,7'h59,7'h59,6'h11,1'b0,3'h2,6'h05,5'h03,16'h2024),
             t(4'h0,7'h00,7'h00,6'h12,1'b1,3'h2,6'h05,5'h03,16'h2024));
        step(t(4'h9,7'h59,7'h59,6'h11,1'b1,3'h2,6'h05,5'h03,16'h2024),
             t(4'h0,7'h00,7'h00,6'h12,1'b0,3'h3,6'h06,5'h03,16'h2024));
        @(posedge clock) mode_12h <= 1'b0;
        step(t(4'h9,7'h59,7'h59,6'h23,1'b0,3'h1,6'h31,5'h12,16'h9999),
             t(4'h0,7'h00,7'h00,6'h00,1'b0,3'h2,6'h01,5'h01,16'h0000));
        step(t(4'h9,7'h59,7'h59,6'h23,1'b0,3'h3,6'h28,5'h02,16'h2023),
             t(4'h0,7'h00,7'h00,6'h00,1'b0,3'h4,6'h01,5'h03,16'h2023));
        step(t(4'h9,7'h59,7'h59,6'h23,1'b0,3'h3,6'h28,5'h02,16'h2100),
             t(4'h0,7'h00,7'h00,6'h00,1'b0,3'h4,6'h01,5'h03,16'h2100));
        gap(128);
        @(posedge clock) frac <= 8'h80;
        gap(192);
        @(posedge clock) smooth_en <= 1'b1;
        gap(192);
        @(posedge clock) frac <= 8'h00;
        int_div <= 16'h0002;
        gap(256);
        @(posedge clock) int_div <= 16'h0001;
        post_mult <= 8'h02;
        gap(256);
        @(posedge clock) post_mult <= 8'h01;
        alm_en <= 8'h00;
        tenth_bypass <= 1'b1;
        step(t(4'h0,7'h58,7'h00,6'h01,1'b0,3'h1,6'h01,5'h01,16'h2000),
             t(4'h0,7'h59,7'h00,6'h01,1'b0,3'h1,6'h01,5'h01,16'h2000));
        gap(128);
        @(posedge clock) sec_sel <= 1'b1;
        gap(1280);
        stop_test;
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #400000;
        n_errors++;
        stop_test;
    end
endmodule // testbench
bind bcca_top bcca_assertions bcca_assertions_inst (.*);
`default_nettype wire
